// >>> design/brtc_pkg.sv
// Shared constants and types for the BCD clock/calendar core
package brtc_pkg;

    // ****************************************************
    // Clock and timing
    // ****************************************************
    localparam int CLK_PERIOD_NS = 5;
    // Silence on the oscillator longer than this counts as a stop
    localparam int STOP_DETECT_NS = 100_000;
    localparam int STOP_DETECT_CYCLES = (STOP_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************
    // Register map
    // ****************************************************
    localparam logic [5:0] ADDR_SEC = 6'h00;
    localparam logic [5:0] ADDR_MIN = 6'h01;
    localparam logic [5:0] ADDR_HOUR = 6'h02;
    localparam logic [5:0] ADDR_WDAY = 6'h03;
    localparam logic [5:0] ADDR_MDAY = 6'h04;
    localparam logic [5:0] ADDR_MON = 6'h05;
    localparam logic [5:0] ADDR_YEAR = 6'h06;
    localparam logic [5:0] ADDR_CTRL = 6'h07;
    localparam logic [5:0] ADDR_RAM_FIRST = 6'h08;
    localparam logic [5:0] ADDR_LAST = 6'h3f;
    localparam int RAM_WORDS = 56;

    // ****************************************************
    // Field positions and masks
    // ****************************************************
    localparam int SEC_HALT_BIT = 7;
    localparam int HOUR_MODE12_BIT = 6;
    localparam int HOUR_PM_BIT = 5;
    localparam int CTRL_OUT_BIT = 7;
    localparam int CTRL_OSF_BIT = 5;
    localparam int CTRL_SQUARE_WAVE_ENABLE_BIT = 4;
    localparam int CTRL_RS_HI_BIT = 1;
    localparam int CTRL_RS_LO_BIT = 0;
    localparam logic [7:0] MASK_SEC = 8'h7f;
    localparam logic [7:0] MASK_MIN = 8'h7f;
    localparam logic [7:0] MASK_HOUR = 8'h7f;
    localparam logic [7:0] MASK_WDAY = 8'h07;
    localparam logic [7:0] MASK_MDAY = 8'h3f;
    localparam logic [7:0] MASK_MON = 8'h1f;
    localparam logic [7:0] MASK_YEAR = 8'hff;

    // ****************************************************
    // Square wave rates and divider taps
    // ****************************************************
    localparam logic [1:0] RATE_1HZ = 2'h0;
    localparam logic [1:0] RATE_4K = 2'h1;
    localparam logic [1:0] RATE_8K = 2'h2;
    localparam logic [1:0] RATE_32K = 2'h3;
    localparam int DIV_WIDTH = 15;
    localparam int TAP_1HZ = 14;
    localparam int TAP_4K = 2;
    localparam int TAP_8K = 1;

    // ****************************************************
    // BCD values and reset values
    // ****************************************************
    localparam logic [7:0] BCD_00 = 8'h00;
    localparam logic [7:0] BCD_01 = 8'h01;
    localparam logic [7:0] BCD_07 = 8'h07;
    localparam logic [7:0] BCD_11 = 8'h11;
    localparam logic [7:0] BCD_12 = 8'h12;
    localparam logic [7:0] BCD_23 = 8'h23;
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [7:0] BCD_99 = 8'h99;
    localparam logic [7:0] BCD_28 = 8'h28;
    localparam logic [7:0] BCD_29 = 8'h29;
    localparam logic [7:0] BCD_30 = 8'h30;
    localparam logic [7:0] BCD_31 = 8'h31;
    localparam logic [7:0] MON_FEB = 8'h02;
    localparam logic [7:0] MON_APR = 8'h04;
    localparam logic [7:0] MON_JUN = 8'h06;
    localparam logic [7:0] MON_SEP = 8'h09;
    localparam logic [7:0] MON_NOV = 8'h11;
    localparam logic RST_HALT = 1'b1;
    localparam logic RST_OSF = 1'b1;

    // ****************************************************
    // Types
    // ****************************************************
    typedef struct packed {
        logic start;
        logic stop;
        logic ptr_wr;
        logic data_wr;
        logic data_rd;
        logic [7:0] data;
    } brtc_bus_req_t;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] mon;
        logic [7:0] mday;
        logic [7:0] wday;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } brtc_time_t;

    localparam brtc_time_t RST_TIME = '{year: 8'h00, mon: 8'h01, mday: 8'h01, wday: 8'h01,
                                        hour: 8'h00, min: 8'h00, sec: 8'h00};

endpackage

// >>> design/brtc_core.sv
// BCD clock/calendar core with register pointer, read snapshot, control byte and user RAM
`timescale 1ns/1ps

module brtc_core #(
    parameter int STOP_DETECT_CYCLES = brtc_pkg::STOP_DETECT_CYCLES,
    parameter int RAM_DEPTH = brtc_pkg::RAM_WORDS,
    parameter int DIV_WIDTH = brtc_pkg::DIV_WIDTH
) (
    // Clocks and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_osc_clk,
    // Byte events from the serial protocol engine
    input wire brtc_pkg::brtc_bus_req_t i_bus,
    // Read data and pointer
    output logic [7:0] o_rd_data,
    output logic [5:0] o_ptr,
    // Oscillator status
    output logic o_osc_running,
    // Open-drain square-wave pin
    output logic o_square_wave_pin_o,
    output logic o_square_wave_pin_oe
);

    // ****************************************************
    // Functions
    // ****************************************************
    function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                            input logic [7:0] first);
        if (v == last) begin
            return first;
        end else if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end else begin
            return v + 8'h01;
        end
    endfunction

    function automatic logic is_leap(input logic [7:0] y);
        if (y[4] == 1'b0) begin
            return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end else begin
            return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
    endfunction

    function automatic logic [7:0] last_day(input logic [7:0] mon, input logic [7:0] year);
        case (mon)
            brtc_pkg::MON_FEB: begin
                return is_leap(year) ? brtc_pkg::BCD_29 : brtc_pkg::BCD_28;
            end
            brtc_pkg::MON_APR, brtc_pkg::MON_JUN, brtc_pkg::MON_SEP, brtc_pkg::MON_NOV: begin
                return brtc_pkg::BCD_30;
            end
            default: begin
                return brtc_pkg::BCD_31;
            end
        endcase
    endfunction

    function automatic logic is_midnight_edge(input logic [7:0] h);
        if (h[brtc_pkg::HOUR_MODE12_BIT]) begin
            return h[brtc_pkg::HOUR_PM_BIT] && ({3'h0, h[4:0]} == brtc_pkg::BCD_11);
        end else begin
            return {2'h0, h[5:0]} == brtc_pkg::BCD_23;
        end
    endfunction

    function automatic logic [7:0] hour_step(input logic [7:0] h);
        logic [7:0] v;
        v = {3'h0, h[4:0]};
        if (h[brtc_pkg::HOUR_MODE12_BIT]) begin
            if (v == brtc_pkg::BCD_12) begin
                return {h[7:5], brtc_pkg::BCD_01[4:0]};
            end else if (v == brtc_pkg::BCD_11) begin
                return {h[7:6], ~h[brtc_pkg::HOUR_PM_BIT], brtc_pkg::BCD_12[4:0]};
            end else begin
                v = bcd_step(v, brtc_pkg::BCD_12, brtc_pkg::BCD_01);
                return {h[7:5], v[4:0]};
            end
        end else begin
            v = bcd_step({2'h0, h[5:0]}, brtc_pkg::BCD_23, brtc_pkg::BCD_00);
            return {h[7:6], v[5:0]};
        end
    endfunction

    // One second of calendar advance, carrying up the chain
    function automatic brtc_pkg::brtc_time_t advance(input brtc_pkg::brtc_time_t t);
        brtc_pkg::brtc_time_t n;
        n = t;
        n.sec = bcd_step(t.sec, brtc_pkg::BCD_59, brtc_pkg::BCD_00);
        if (t.sec == brtc_pkg::BCD_59) begin
            n.min = bcd_step(t.min, brtc_pkg::BCD_59, brtc_pkg::BCD_00);
            if (t.min == brtc_pkg::BCD_59) begin
                n.hour = hour_step(t.hour);
                if (is_midnight_edge(t.hour)) begin
                    n.wday = (t.wday == brtc_pkg::BCD_07) ? brtc_pkg::BCD_01 : t.wday + 8'h01;
                    n.mday = bcd_step(t.mday, last_day(t.mon, t.year), brtc_pkg::BCD_01);
                    if (t.mday == last_day(t.mon, t.year)) begin
                        n.mon = bcd_step(t.mon, brtc_pkg::BCD_12, brtc_pkg::BCD_01);
                        if (t.mon == brtc_pkg::BCD_12) begin
                            n.year = bcd_step(t.year, brtc_pkg::BCD_99, brtc_pkg::BCD_00);
                        end
                    end
                end
            end
        end
        return n;
    endfunction

    function automatic logic [7:0] time_mask(input logic [5:0] a);
        case (a)
            brtc_pkg::ADDR_SEC: return brtc_pkg::MASK_SEC;
            brtc_pkg::ADDR_MIN: return brtc_pkg::MASK_MIN;
            brtc_pkg::ADDR_HOUR: return brtc_pkg::MASK_HOUR;
            brtc_pkg::ADDR_WDAY: return brtc_pkg::MASK_WDAY;
            brtc_pkg::ADDR_MDAY: return brtc_pkg::MASK_MDAY;
            brtc_pkg::ADDR_MON: return brtc_pkg::MASK_MON;
            brtc_pkg::ADDR_YEAR: return brtc_pkg::MASK_YEAR;
            default: return 8'h00;
        endcase
    endfunction

    // ****************************************************
    // Oscillator domain
    // ****************************************************
    logic osc_rst_s1;
    logic osc_rst_s2;
    logic osc_halt_s1;
    logic osc_halt_s2;
    logic osc_clr_s1;
    logic osc_clr_s2;
    logic osc_clr_s3;
    logic osc_clr;
    // Top divider bit is the 1Hz wave and its wrap is the second tick
    logic [DIV_WIDTH-1:0] div_r;
    logic tick_tgl_r;
    logic act_tgl_r;
    logic halt_r;
    logic clr_tgl_r;

    always_ff @(posedge i_osc_clk) begin
        osc_rst_s1 <= i_rst_n;
        osc_rst_s2 <= osc_rst_s1;
        osc_halt_s1 <= halt_r;
        osc_halt_s2 <= osc_halt_s1;
        osc_clr_s1 <= clr_tgl_r;
        osc_clr_s2 <= osc_clr_s1;
        osc_clr_s3 <= osc_clr_s2;
    end

    assign osc_clr = osc_clr_s2 ^ osc_clr_s3;

    // Divider restarts from zero so the 1Hz tap rises half a second later
    always_ff @(posedge i_osc_clk) begin
        if (!osc_rst_s2) begin
            div_r <= '0;
        end else if (osc_clr) begin
            div_r <= '0;
        end else if (!osc_halt_s2) begin
            div_r <= div_r + 1'b1;
        end
    end

    always_ff @(posedge i_osc_clk) begin
        if (!osc_rst_s2) begin
            tick_tgl_r <= 1'b0;
            act_tgl_r <= 1'b0;
        end else begin
            if (!osc_halt_s2 && !osc_clr && (&div_r)) begin
                tick_tgl_r <= ~tick_tgl_r;
            end
            if (!osc_halt_s2) begin
                act_tgl_r <= ~act_tgl_r;
            end
        end
    end

    // ****************************************************
    // Crossings into the core domain
    // ****************************************************
    logic tick_s1;
    logic tick_s2;
    logic tick_s3;
    logic act_s1;
    logic act_s2;
    logic act_s3;
    logic [2:0] tap_s1;
    logic [2:0] tap_s2;
    logic oscl_s1;
    logic oscl_s2;
    logic sec_tick;

    // Divider bits cross as independent levels; each feeds the pin alone
    always_ff @(posedge i_core_clk) begin
        tick_s1 <= tick_tgl_r;
        tick_s2 <= tick_s1;
        tick_s3 <= tick_s2;
        act_s1 <= act_tgl_r;
        act_s2 <= act_s1;
        act_s3 <= act_s2;
        tap_s1 <= {div_r[DIV_WIDTH-1], div_r[brtc_pkg::TAP_8K], div_r[brtc_pkg::TAP_4K]};
        tap_s2 <= tap_s1;
        oscl_s1 <= i_osc_clk;
        oscl_s2 <= oscl_s1;
    end

    assign sec_tick = tick_s2 ^ tick_s3;

    // ****************************************************
    // Oscillator stop detection
    // ****************************************************
    logic [31:0] idle_cnt_r;
    logic running;
    logic running_r;

    // Start out as stopped, so no false run is reported while the halt bit holds
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            idle_cnt_r <= 32'(STOP_DETECT_CYCLES);
        end else if (act_s2 ^ act_s3) begin
            idle_cnt_r <= '0;
        end else if (idle_cnt_r < 32'(STOP_DETECT_CYCLES)) begin
            idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
        end
    end

    assign running = idle_cnt_r < 32'(STOP_DETECT_CYCLES);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            running_r <= 1'b0;
        end else begin
            running_r <= running;
        end
    end

    // ****************************************************
    // Register pointer and snapshot triggers
    // ****************************************************
    logic [5:0] ptr_r;
    logic [5:0] ptr_nxt;
    logic byte_done;
    logic wrap_zero;
    logic snap_take;

    assign byte_done = i_bus.data_wr | i_bus.data_rd;
    assign wrap_zero = byte_done && (ptr_r == brtc_pkg::ADDR_LAST);
    assign snap_take = i_bus.start | i_bus.stop | wrap_zero;

    always_comb begin
        ptr_nxt = ptr_r;
        if (i_bus.ptr_wr) begin
            ptr_nxt = i_bus.data[5:0];
        end else if (byte_done) begin
            ptr_nxt = ptr_r + 6'h01;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ptr_r <= brtc_pkg::ADDR_SEC;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // ****************************************************
    // Live time, halt and chain clear
    // ****************************************************
    brtc_pkg::brtc_time_t live_r;
    brtc_pkg::brtc_time_t live_nxt;
    brtc_pkg::brtc_time_t snap_r;
    logic wr_time;
    logic wr_sec;
    logic [7:0] wr_val;

    assign wr_time = i_bus.data_wr && (ptr_r < brtc_pkg::ADDR_CTRL);
    assign wr_sec = i_bus.data_wr && (ptr_r == brtc_pkg::ADDR_SEC);
    assign wr_val = i_bus.data & time_mask(ptr_r);

    // A seconds write drops a tick that arrives in the same cycle, since the chain restarts
    always_comb begin
        live_nxt = live_r;
        if (sec_tick && !halt_r && !wr_sec) begin
            live_nxt = advance(live_r);
        end
        if (wr_time) begin
            case (ptr_r)
                brtc_pkg::ADDR_SEC: live_nxt.sec = wr_val;
                brtc_pkg::ADDR_MIN: live_nxt.min = wr_val;
                brtc_pkg::ADDR_HOUR: live_nxt.hour = wr_val;
                brtc_pkg::ADDR_WDAY: live_nxt.wday = wr_val;
                brtc_pkg::ADDR_MDAY: live_nxt.mday = wr_val;
                brtc_pkg::ADDR_MON: live_nxt.mon = wr_val;
                default: live_nxt.year = wr_val;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            live_r <= brtc_pkg::RST_TIME;
        end else begin
            live_r <= live_nxt;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            snap_r <= brtc_pkg::RST_TIME;
        end else if (snap_take) begin
            snap_r <= live_r;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            halt_r <= brtc_pkg::RST_HALT;
            clr_tgl_r <= 1'b0;
        end else if (wr_sec) begin
            halt_r <= i_bus.data[brtc_pkg::SEC_HALT_BIT];
            clr_tgl_r <= ~clr_tgl_r;
        end
    end

    // ****************************************************
    // Control register
    // ****************************************************
    logic out_r;
    logic square_wave_enable_r;
    logic [1:0] rate_r;
    logic osf_r;
    logic wr_ctrl;
    logic osf_set;
    logic osf_clr;

    assign wr_ctrl = i_bus.data_wr && (ptr_r == brtc_pkg::ADDR_CTRL);
    assign osf_set = (running_r && !running) || (wr_sec && i_bus.data[brtc_pkg::SEC_HALT_BIT]);
    assign osf_clr = wr_ctrl && !i_bus.data[brtc_pkg::CTRL_OSF_BIT];

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            osf_r <= brtc_pkg::RST_OSF;
        end else begin
            osf_r <= osf_set | (osf_r & ~osf_clr);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            out_r <= 1'b0;
            square_wave_enable_r <= 1'b0;
            rate_r <= brtc_pkg::RATE_1HZ;
        end else if (wr_ctrl) begin
            out_r <= i_bus.data[brtc_pkg::CTRL_OUT_BIT];
            square_wave_enable_r <= i_bus.data[brtc_pkg::CTRL_SQUARE_WAVE_ENABLE_BIT];
            rate_r <= {i_bus.data[brtc_pkg::CTRL_RS_HI_BIT], i_bus.data[brtc_pkg::CTRL_RS_LO_BIT]};
        end
    end

    // ****************************************************
    // User RAM
    // ****************************************************
    logic [7:0] ram_r [RAM_DEPTH];
    logic [5:0] ram_idx;

    assign ram_idx = ptr_r - brtc_pkg::ADDR_RAM_FIRST;

    // Contents are undefined after power-up, so the array has no reset
    always_ff @(posedge i_core_clk) begin
        if (i_bus.data_wr && (ptr_r >= brtc_pkg::ADDR_RAM_FIRST)) begin
            ram_r[ram_idx] <= i_bus.data;
        end
    end

    // ****************************************************
    // Read data
    // ****************************************************
    logic [7:0] rd_val;
    logic [7:0] o_rd_data_r;

    always_comb begin
        rd_val = 8'h00;
        case (ptr_r)
            brtc_pkg::ADDR_SEC: rd_val = {halt_r, snap_r.sec[6:0]};
            brtc_pkg::ADDR_MIN: rd_val = snap_r.min;
            brtc_pkg::ADDR_HOUR: rd_val = snap_r.hour;
            brtc_pkg::ADDR_WDAY: rd_val = snap_r.wday;
            brtc_pkg::ADDR_MDAY: rd_val = snap_r.mday;
            brtc_pkg::ADDR_MON: rd_val = snap_r.mon;
            brtc_pkg::ADDR_YEAR: rd_val = snap_r.year;
            brtc_pkg::ADDR_CTRL: begin
                rd_val[brtc_pkg::CTRL_OUT_BIT] = out_r;
                rd_val[brtc_pkg::CTRL_OSF_BIT] = osf_r;
                rd_val[brtc_pkg::CTRL_SQUARE_WAVE_ENABLE_BIT] = square_wave_enable_r;
                rd_val[brtc_pkg::CTRL_RS_HI_BIT] = rate_r[1];
                rd_val[brtc_pkg::CTRL_RS_LO_BIT] = rate_r[0];
            end
            default: rd_val = ram_r[ram_idx];
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_rd_data_r <= 8'h00;
        end else begin
            o_rd_data_r <= rd_val;
        end
    end

    // ****************************************************
    // Square-wave pin
    // ****************************************************
    logic wave;
    logic pin_level_r;

    // The 32.768kHz rate is the sampled oscillator itself, so it carries 5ns of jitter
    always_comb begin
        case (rate_r)
            brtc_pkg::RATE_1HZ: wave = tap_s2[2];
            brtc_pkg::RATE_4K: wave = tap_s2[0];
            brtc_pkg::RATE_8K: wave = tap_s2[1];
            default: wave = oscl_s2 & ~halt_r;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pin_level_r <= 1'b0;
        end else begin
            pin_level_r <= square_wave_enable_r ? wave : out_r;
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign o_rd_data = o_rd_data_r;
    assign o_ptr = ptr_r;
    assign o_osc_running = running_r;
    assign o_square_wave_pin_o = 1'b0;
    assign o_square_wave_pin_oe = ~pin_level_r;

endmodule

// >>> verification/brtc_master.sv
// Bus master model handing byte events to the clock core
`timescale 1ns/1ps
module brtc_master (
    // Clock and read data
    input wire logic i_core_clk,
    input wire logic [7:0] i_rd_data,
    // Byte events
    output brtc_pkg::brtc_bus_req_t o_bus
);
    initial o_bus = '0;
    // One event per pulse; the released byte is inverted so stale data cannot pass
    task automatic ev(input int k, input logic [7:0] d);
        brtc_pkg::brtc_bus_req_t r;
        r = '0;
        r.data = d;
        case (k)
            0: r.start = 1'b1;
            1: r.stop = 1'b1;
            2: r.ptr_wr = 1'b1;
            3: r.data_wr = 1'b1;
            default: r.data_rd = 1'b1;
        endcase
        @(posedge i_core_clk);
        #1;
        o_bus = r;
        @(posedge i_core_clk);
        #1;
        o_bus = {5'h00, ~d};
    endtask
    // Frames follow at once, far inside one second; hours keep one format
    task automatic wr1(input logic [5:0] a, input logic [7:0] d);
        ev(0, 8'h00);
        ev(2, {2'b00, a});
        ev(3, d);
        ev(1, 8'h00);
    endtask
    task automatic rdn(output logic [7:0] d);
        ev(0, 8'h00);
        repeat (2) @(posedge i_core_clk);
        #1;
        d = i_rd_data;
        ev(4, 8'h00);
        ev(1, 8'h00);
    endtask
    task automatic rd1(input logic [5:0] a, output logic [7:0] d);
        ev(0, 8'h00);
        ev(2, {2'b00, a});
        rdn(d);
    endtask
endmodule

// >>> verification/brtc_core_checker.sv
// Port checker for the clock core
`timescale 1ns/1ps
module brtc_core_checker #(
    parameter int STOP_DETECT_CYCLES = 40,
    parameter int RAM_DEPTH = 56
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_osc_clk,
    input wire brtc_pkg::brtc_bus_req_t i_bus,
    input wire logic [7:0] o_rd_data,
    input wire logic [5:0] o_ptr,
    input wire logic o_osc_running,
    input wire logic o_square_wave_pin_o,
    input wire logic o_square_wave_pin_oe
);
    logic quiet;
    assign quiet = !(i_bus.start || i_bus.stop || i_bus.ptr_wr || i_bus.data_wr || i_bus.data_rd);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    chk_ptr_load: assert property (i_bus.ptr_wr |=> o_ptr == $past(i_bus.data[5:0]))
        else $error("pointer not loaded");
    chk_ptr_step: assert property ((i_bus.data_wr || i_bus.data_rd) |=> o_ptr == $past(o_ptr) + 6'h01)
        else $error("pointer not stepped");
    chk_ptr_wrap: assert property ((i_bus.data_rd && o_ptr == 6'h3f) |=> o_ptr == 6'h00)
        else $error("pointer not wrapped");
    chk_ptr_hold: assert property (quiet |=> $stable(o_ptr))
        else $error("pointer moved unasked");
    chk_pin_drain: assert property (o_square_wave_pin_o == 1'b0)
        else $error("pin driven high");
    chk_ctrl_zero: assert property ((quiet && o_ptr == 6'h07)[*3] |-> (o_rd_data & 8'h4c) == 8'h00)
        else $error("control spare bits set");
    chk_wday_zero: assert property ((quiet && o_ptr == 6'h03)[*3] |-> o_rd_data[7:3] == 5'h00)
        else $error("weekday spare bits set");
    chk_top_zero: assert property ((quiet && o_ptr inside {6'h01, 6'h02, 6'h04, 6'h05})[*3]
        |-> !o_rd_data[7])
        else $error("time spare bit set");
    chk_halt_stop: assert property ((i_bus.data_wr && o_ptr == 6'h00 && i_bus.data[7])
        |-> ##[1:300] !o_osc_running)
        else $error("halt did not stop oscillator");
endmodule
bind brtc_core brtc_core_checker #(.STOP_DETECT_CYCLES(STOP_DETECT_CYCLES), .RAM_DEPTH(RAM_DEPTH)) u_chk (
    .i_core_clk, .i_rst_n, .i_osc_clk, .i_bus, .o_rd_data, .o_ptr, .o_osc_running,
    .o_square_wave_pin_o, .o_square_wave_pin_oe);

// >>> verification/brtc_core_tb.sv
// Self-checking bench for the clock core
`timescale 1ns/1ps
module brtc_core_tb;
    logic i_core_clk = 1'b0;
    logic i_osc_clk = 1'b0;
    logic i_rst_n = 1'b0;
    brtc_pkg::brtc_bus_req_t bus;
    logic [7:0] rd;
    logic [7:0] d;
    logic [5:0] ptr;
    logic run;
    logic oe;
    int n_errors = 0;
    int n_compared = 0;
    initial forever #2.5 i_core_clk = ~i_core_clk;
    // Free running oscillator, phase unrelated to the core clock
    initial begin
        #1.3;
        forever #16 i_osc_clk = ~i_osc_clk;
    end
    brtc_master m (.i_core_clk, .i_rd_data(rd), .o_bus(bus));
    // A narrow divider makes one second 256 oscillator cycles, so rollover fits in the run
    brtc_core #(.STOP_DETECT_CYCLES(40), .DIV_WIDTH(8)) dut (.i_core_clk, .i_rst_n, .i_osc_clk, .i_bus(bus),
        .o_rd_data(rd), .o_ptr(ptr), .o_osc_running(run), .o_square_wave_pin_o(), .o_square_wave_pin_oe(oe));
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] e, input logic [7:0] g, input int tol = 0);
        n_compared++;
        if ((^g) === 1'bx || g + tol < e || g > e + tol) begin
            n_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    // Bounded wait on the pin or the running flag; a level that never comes ends the run
    task automatic wait_lvl(input bit on_pin, input logic v, input int n);
        logic s;
        s = on_pin ? oe : run;
        for (int i = 0; i < n && s !== v; i++) begin
            @(posedge i_core_clk);
            #1;
            s = on_pin ? oe : run;
        end
        if (s !== v) begin
            n_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, v, s);
            finish_test();
        end
    endtask
    task automatic t_ram();
        m.wr1(6'h3f, 8'ha5);
        m.wr1(6'h08, 8'h11);
        m.wr1(6'h09, 8'h22);
        m.rd1(6'h08, d);
        check(8'h11, d);
        m.rdn(d);
        check(8'h22, d);
        m.rd1(6'h3f, d);
        check(8'ha5, d);
        check(8'h00, {2'b00, ptr});
        $display("t_ram done");
    endtask
    task automatic t_ctrl();
        m.wr1(6'h07, 8'hff);
        m.rd1(6'h07, d);
        check(8'hb3, d);
        m.wr1(6'h07, 8'h00);
        m.rd1(6'h07, d);
        check(8'h00, d);
        check(8'h01, {7'h00, oe});
        m.wr1(6'h03, 8'hff);
        m.rd1(6'h03, d);
        check(8'h07, d);
        m.wr1(6'h07, 8'h80);
        repeat (8) @(posedge i_core_clk);
        #1;
        check(8'h00, {7'h00, oe});
        $display("t_ctrl done");
    endtask
    task automatic t_osc();
        m.wr1(6'h00, 8'h00);
        wait_lvl(1'b0, 1'b1, 3000);
        m.wr1(6'h07, 8'h00);
        m.wr1(6'h00, 8'h80);
        wait_lvl(1'b0, 1'b0, 300);
        m.rd1(6'h07, d);
        check(8'h20, d);
        m.rd1(6'h00, d);
        check(8'h80, d & 8'h80);
        m.wr1(6'h00, 8'h00);
        wait_lvl(1'b0, 1'b1, 3000);
        $display("t_osc done");
    endtask
    task automatic t_rates();
        int cnt;
        logic prev;
        int exp [3] = '{16, 32, 128};
        for (int r = 1; r < 4; r++) begin
            m.wr1(6'h07, 8'h10 | 8'(r));
            repeat (20) @(posedge i_core_clk);
            #1;
            cnt = 0;
            prev = oe;
            repeat (410) begin
                @(posedge i_core_clk);
                #1;
                if (oe !== prev) cnt++;
                prev = oe;
            end
            check(8'(exp[r - 1]), 8'(cnt), 2);
        end
        $display("t_rates done");
    endtask
    task automatic t_half();
        m.wr1(6'h07, 8'h10);
        m.wr1(6'h00, 8'h00);
        #3900;
        check(8'h01, {7'h00, oe});
        wait_lvl(1'b1, 1'b0, 300);
        $display("t_half done");
    endtask
    // Set 11:59:59 PM on February 28 of a leap year, then let one second pass
    task automatic t_roll();
        m.wr1(6'h00, 8'h80);
        m.wr1(6'h01, 8'h59);
        m.wr1(6'h02, 8'h71);
        m.wr1(6'h03, 8'h07);
        m.wr1(6'h04, 8'h28);
        m.wr1(6'h05, 8'h02);
        m.wr1(6'h06, 8'h00);
        m.wr1(6'h00, 8'h59);
        #10000;
        m.rd1(6'h02, d);
        check(8'h52, d);
        m.rd1(6'h03, d);
        check(8'h01, d);
        m.rd1(6'h04, d);
        check(8'h29, d);
        $display("t_roll done");
    endtask
    initial begin
        repeat (40) @(posedge i_core_clk);
        #1;
        i_rst_n = 1'b1;
        t_ram();
        t_ctrl();
        t_osc();
        t_rates();
        t_half();
        t_roll();
        finish_test();
    end
endmodule
